// >>> verilog/program_status_flags.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RQ1 - ALU carry out sets carry flag bit 7
// RQ2 - Carry flag is Boolean bit accumulator
// RQ3 - Nibble carry sets aux carry bit 6
// RQ4 - User flags bits 5, 1 freely writable
// RQ5 - Overflow bit 2 is carry6 xor carry7
// RQ6 - Parity bit 0 tracks accumulator ones
// RQ7 - Bank select bits 4:3 pick register window
// RQ8 - Parity recomputed; writes to it ignored
module program_status_flags (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Status word to the core
  output logic [7:0] status_word,
  output logic [4:0] bank_base
);

  function automatic logic odd_parity(input logic [7:0] v);
    return ^v;
  endfunction

  // Add with carry in; gathers nibble, bit-6 and bit-7 carries
  function automatic status_word_pkg::alu_out_s add8(input logic [7:0] a, input logic [7:0] b,
                                                      input logic ci);
    logic [4:0] lo;
    logic [7:0] lo7;
    logic [8:0] full;
    status_word_pkg::alu_out_s r;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    lo7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, ci};
    full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    r.carry = full[8]; // RQ1
    r.aux = lo[4]; // RQ3
    r.ovf = lo7[7] ^ full[8]; // RQ5
    r.result = full[7:0];
    return r;
  endfunction

  logic [7:0] flags;
  logic [7:0] acc;
  logic [7:0] next_flags;
  logic [7:0] next_acc;
  logic next_awready, next_wready, next_arready;
  logic [4:0] next_bank_base;
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held, next_w_held;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_write;
  status_word_pkg::alu_out_s alu;

  // Write address and data are taken in either order, one write at a time
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_comb begin
    logic [7:0] b;
    logic c;
    b = 8'h00;
    c = 1'b0;
    next_flags = flags;
    next_acc = acc;
    alu = add8(acc, 8'h00, 1'b0);
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = status_word_pkg::AXI_OKAY;
      case (aw_addr)
        status_word_pkg::STATUS_WORD_ADDR: begin
          // User flags and bank select have no side effects
          if (w_strb[0]) begin
            next_flags = w_data[7:0]; // RQ4 RQ7
          end
        end
        status_word_pkg::ACC_ADDR: begin
          if (w_strb[0]) begin
            next_acc = w_data[7:0];
          end
        end
        status_word_pkg::ALU_OP_ADDR: begin
          if (w_strb[0] && w_strb[1]) begin
            b = w_data[15:8];
            c = flags[status_word_pkg::CARRY_BIT];
            case (status_word_pkg::alu_op_e'(w_data[2:0]))
              status_word_pkg::OP_ADD, status_word_pkg::OP_ADDC: begin
                alu = add8(acc, b, (w_data[2:0] == 3'h1) ? c : 1'b0);
                next_acc = alu.result;
                next_flags[status_word_pkg::CARRY_BIT] = alu.carry; // RQ1
                next_flags[status_word_pkg::AUX_BIT] = alu.aux; // RQ3
                next_flags[status_word_pkg::OVF_BIT] = alu.ovf; // RQ5
              end
              status_word_pkg::OP_SUBB: begin
                // Subtract as add of complement; carry reads as borrow
                alu = add8(acc, ~b, ~c);
                next_acc = alu.result;
                next_flags[status_word_pkg::CARRY_BIT] = ~alu.carry; // RQ1
                next_flags[status_word_pkg::AUX_BIT] = ~alu.aux; // RQ3
                next_flags[status_word_pkg::OVF_BIT] = alu.ovf; // RQ5
              end
              // Boolean ops use carry as the one-bit accumulator
              status_word_pkg::OP_SETC: next_flags[status_word_pkg::CARRY_BIT] = 1'b1; // RQ2
              status_word_pkg::OP_CLRC: next_flags[status_word_pkg::CARRY_BIT] = 1'b0; // RQ2
              status_word_pkg::OP_CPLC: next_flags[status_word_pkg::CARRY_BIT] = ~c; // RQ2
              status_word_pkg::OP_ANLC: begin
                next_flags[status_word_pkg::CARRY_BIT] = c & w_data[8]; // RQ2
              end
              status_word_pkg::OP_ORLC: begin
                next_flags[status_word_pkg::CARRY_BIT] = c | w_data[8]; // RQ2
              end
              default: next_flags = flags;
            endcase
          end
        end
        default: next_bresp = status_word_pkg::AXI_SLVERR;
      endcase
    end
    // Parity always follows the accumulator, overriding any write
    next_flags[status_word_pkg::PARITY_BIT] = odd_parity(next_acc); // RQ6 RQ8
  end

  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = status_word_pkg::AXI_OKAY;
      case (s_axi_araddr)
        status_word_pkg::STATUS_WORD_ADDR: next_rdata = {24'h000000, flags};
        status_word_pkg::ACC_ADDR: next_rdata = {24'h000000, acc};
        status_word_pkg::ALU_OP_ADDR: next_rdata = 32'h00000000;
        status_word_pkg::BANK_BASE_ADDR: next_rdata = {27'h0000000, bank_base};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = status_word_pkg::AXI_SLVERR;
        end
      endcase
    end
  end

  // Ready only while the holding slot is free and no response pends
  always_comb begin
    next_awready = !next_aw_held && !next_bvalid && !(s_axi_awvalid && s_axi_awready);
    next_wready = !next_w_held && !next_bvalid && !(s_axi_wvalid && s_axi_wready);
    next_arready = !next_rvalid && !(s_axi_arvalid && s_axi_arready);
    // Bank n covers bytes 8n..8n+7 of low data memory
    next_bank_base = 5'(next_flags[status_word_pkg::BANK_HI_BIT:status_word_pkg::BANK_LO_BIT])
                     << status_word_pkg::BANK_SHIFT; // RQ7
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= status_word_pkg::STATUS_RESET;
      acc <= status_word_pkg::ACC_RESET;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
      status_word <= 8'h00;
      bank_base <= 5'h00;
    end else begin
      flags <= next_flags;
      acc <= next_acc;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      status_word <= next_flags;
      bank_base <= next_bank_base; // RQ7
    end
  end

endmodule
`default_nettype wire

// >>> verilog/status_word_pkg.sv
`default_nettype none
package status_word_pkg;
  // Register map (byte address on the register bus)
  localparam logic [7:0] STATUS_WORD_ADDR = 8'hD0;
  localparam logic [7:0] ALU_OP_ADDR = 8'hD4;
  localparam logic [7:0] ACC_ADDR = 8'hD8;
  localparam logic [7:0] BANK_BASE_ADDR = 8'hDC;
  // Field positions
  localparam int CARRY_BIT = 7;
  localparam int AUX_BIT = 6;
  localparam int USER0_BIT = 5;
  localparam int BANK_HI_BIT = 4;
  localparam int BANK_LO_BIT = 3;
  localparam int OVF_BIT = 2;
  localparam int USER1_BIT = 1;
  localparam int PARITY_BIT = 0;
  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  // Each bank spans eight bytes
  localparam int BANK_SHIFT = 3;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ALU operation codes written to the op register bits [2:0]
  typedef enum logic [2:0] {
    OP_ADD, OP_ADDC, OP_SUBB, OP_SETC, OP_CLRC, OP_CPLC, OP_ANLC, OP_ORLC
  } alu_op_e;

  typedef struct packed {
    logic carry;
    logic aux;
    logic ovf;
    logic [7:0] result;
  } alu_out_s;
endpackage
`default_nettype wire

// >>> sim/program_status_flags_sva.sv
`timescale 1ns/10ps
`default_nettype none
module program_status_flags_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side
  input wire logic [7:0] status_word,
  input wire logic [4:0] bank_base
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] wd;
  logic wr, ws, wa, wo;
  // Bench offers both channels together, so one edge takes both
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  assign ws = wr && s_axi_awaddr == status_word_pkg::STATUS_WORD_ADDR;
  assign wa = wr && s_axi_awaddr == status_word_pkg::ACC_ADDR;
  assign wo = wr && s_axi_awaddr == status_word_pkg::ALU_OP_ADDR && s_axi_wstrb[1];
  always_ff @(posedge aclk) if (wr) wd <= s_axi_wdata[7:0];
  property p_user; ws |-> ##[1:3] status_word[7:1] == wd[7:1]; endproperty
  a_user: assert property (p_user) else $error("status write not applied");
  property p_par; wa |-> ##[1:3] status_word[0] == ^wd; endproperty
  a_par: assert property (p_par) else $error("parity wrong");
  property p_keep; ws |=> $stable(status_word[0]) [*3]; endproperty
  a_keep: assert property (p_keep) else $error("parity bit written");
  property p_setc; wo && s_axi_wdata[2:0] == 3'h3 |-> ##[1:3] status_word[7]; endproperty
  a_setc: assert property (p_setc) else $error("carry not set");
  property p_bank; $stable(status_word) |-> bank_base == {status_word[4:3], 3'h0}; endproperty
  a_bank: assert property (p_bank) else $error("bank base wrong");
  property p_bwin; s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid; endproperty
  a_bwin: assert property (p_bwin) else $error("no write response");
  property p_rwin; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rwin: assert property (p_rwin) else $error("no read data");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_arr; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arr: assert property (p_arr) else $error("read taken while busy");
  c_ws: cover property (ws);
  c_wo: cover property (wo);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind program_status_flags program_status_flags_sva u_sva (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .status_word(status_word), .bank_base(bank_base)
);
`default_nettype wire

// >>> sim/program_status_flags_bench.sv
`timescale 1ns/10ps
`default_nettype none
module program_status_flags_bench;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, status_word;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [4:0] bank_base;
  int errors = 0, n_compared = 0;
  // Address, write data, expected status word
  localparam logic [31:0] ROWS [16] = '{32'hD8003C00, 32'hD4C800C1, 32'hD47B0145,
    32'hD4010245, 32'hD40003C5, 32'hD4000545, 32'hD40107C5, 32'hD4000645, 32'hD40005C5,
    32'hD4000445, 32'hD0003A3B, 32'hD0000001, 32'hD0000809, 32'hD0001011, 32'hD8000310,
    32'hD0000100};
  always #12.5 aclk = ~aclk;
  program_status_flags u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .status_word(status_word), .bank_base(bank_base)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    bit aw = 1'b1, w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Late ready keeps the slave holding its answer a while
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rst;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(status_word), 32'h0);
    chk(32'(bank_base), 32'h0);
  endtask
  task automatic finish_test;
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    @(posedge aclk);
    rst;
    foreach (ROWS[i]) begin
      wr(ROWS[i][31:24], ROWS[i][23:8]);
      chk(32'(r), 32'(status_word_pkg::AXI_OKAY));
      rd(status_word_pkg::STATUS_WORD_ADDR);
      chk(32'(r), 32'(status_word_pkg::AXI_OKAY));
      chk(d, {24'h0, ROWS[i][7:0]});
      chk(32'(status_word), {24'h0, ROWS[i][7:0]});
      chk(32'(bank_base), {27'h0, ROWS[i][4:3], 3'h0});
    end
    wr(8'hE0, 16'h00FF);
    chk(32'(r), 32'(status_word_pkg::AXI_SLVERR));
    rd(8'hE0);
    chk(32'(r), 32'(status_word_pkg::AXI_SLVERR));
    chk(d, 32'h0);
    rd(status_word_pkg::ALU_OP_ADDR);
    chk(d, 32'h0);
    rd(status_word_pkg::ACC_ADDR);
    chk(d, 32'h3);
    chk(32'(status_word), 32'h0);
    wr(status_word_pkg::STATUS_WORD_ADDR, 16'h0018);
    chk(32'(status_word), 32'h18);
    rd(status_word_pkg::BANK_BASE_ADDR);
    chk(d, 32'h18);
    rst;
    rd(status_word_pkg::ACC_ADDR);
    chk(d, 32'h0);
    finish_test;
  end
  initial begin
    repeat (4000) @(posedge aclk);
    errors++;
    finish_test;
  end
endmodule
`default_nettype wire
